// *** hdl/frwic_top.sv ***
// Flash rewrite sequencer with interrupt, suspend and abort control.
// Assumes a classic Wishbone master and a CPU interrupt controller on REF_CLK.
`timescale 1ns/10ps
`include "frwic_map.svh"

// What this block and its software do
// R1: Data-flash erase, auto-suspend enabled, interrupt taken: set suspend request.
// R2: Suspend request halts erase after suspend latency.
// R3: With auto-suspend off, handler software sets suspend request itself.
// R4: While suspended, every block except interrupted one stays accessible.
// R5: Clearing suspend request resumes the suspended erase.
// R6: Data-flash program or unsuspended erase lets interrupts run alongside.
// R7: Watchdog, oscillator or voltage interrupt aborts program-area work.
// R8: After abort, interrupt handling waits for flash recovery period.
// R9: Software re-erases aborted block and checks completion.
// R10: Watchdog keeps running; software services it via erase suspend.
// R11: Software avoids trap and debug interrupts during program-area work.
// R12: Software allows no non-maskable interrupt while block 0 erases.
// R13: Protected enables take 1 only after write 0 then write 1.
// R14: Lock bits take 0 only after write 1 then write 0.
// R15: Software never programs an already programmed address again.
// R16: Software avoids stop or wait while erase is suspended.
// R17: Software avoids stop or wait while flag shows busy.
// R18: Software clears low-current read before stop or wait.
// R19: Software issues no blank check while erase is suspended.
// R20: Low-current read only on slow oscillator divided by 4, 8, 16.
// R21: No low-current read at CPU clock of 3 kHz or less.
// R22: Set clock divide first, then low-current read enable.
// R23: Ready/busy shows busy from acceptance to completion, suspend or abort.
module frwic_top #(
   parameter int ERASE_CYC = `FRWIC_ERASE_CYC,
   parameter int PROG_CYC  = `FRWIC_PROG_CYC,
   parameter int RECOV_CYC = `FRWIC_RECOV_CYC
) (
   // Clock and reset
   input  wire logic        REF_CLK,
   input  wire logic        ARST_N,
   // Wishbone slave
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [5:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   // Interrupt acknowledge from the CPU
   input  wire logic        IRQ_ACK,
   input  wire logic        IRQ_ACK_FATAL,
   output logic             IRQ_HOLD,
   // Array access from the CPU side
   input  wire frwic_pkg::frwic_acc_t ARRAY_ACC,
   output logic             ARRAY_GRANT,
   // Flash state outputs
   output logic             FLASH_RESET,
   output logic             LOW_CURRENT_READ
);

   // ****************************************
   // Declarations
   // ****************************************
   frwic_pkg::frwic_state_t state_reg;
   frwic_pkg::frwic_cmd_t   op_reg;
   logic [3:0]  ctrl_reg;
   logic [2:0]  prot_reg;
   logic [3:0]  lock_reg;
   logic [2:0]  arm_reg;
   logic [3:0]  unlock_arm_reg;
   logic [2:0]  parm_reg;
   logic [2:0]  prot_set;
   logic        abort_reg;
   logic [15:0] cnt_reg;
   logic [15:0] done_reg;
   logic        ack_reg;
   logic [31:0] rdata_reg;
   logic        wr_stb;
   logic        rd_stb;
   logic        cmd_go;
   logic        busy;
   logic        auto_sus;
   logic        fatal_abort;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic hit(input logic [5:0] ofs);
      hit = (WB_ADR_I == ofs);
   endfunction

   function automatic logic [15:0] op_len(input logic [1:0] c);
      op_len = (c == `FRWIC_CMD_ERASE) ? ERASE_CYC[15:0] : PROG_CYC[15:0];
   endfunction

   // ****************************************
   // Bus strobes
   // ****************************************
   assign wr_stb = WB_CYC_I && WB_STB_I && WB_WE_I && !ack_reg
                   && WB_SEL_I[0];
   assign rd_stb = WB_CYC_I && WB_STB_I && !WB_WE_I && !ack_reg;
   assign busy   = (state_reg == frwic_pkg::ST_RUN) ||
                   (state_reg == frwic_pkg::ST_SUS_WAIT);
   assign cmd_go = wr_stb && hit(`FRWIC_OFS_CMD) && ctrl_reg[`FRWIC_CTRL_CPUREN]
                   && (state_reg == frwic_pkg::ST_IDLE)
                   && (WB_DAT_I[1:0] != 2'h0);
   // Auto suspend only for a data-flash erase
   assign auto_sus = IRQ_ACK && ctrl_reg[`FRWIC_CTRL_SUSIEN] && busy
                     && !op_reg.area_prog
                     && (op_reg.cmd == `FRWIC_CMD_ERASE); // R1
   assign fatal_abort = IRQ_ACK_FATAL && op_reg.area_prog
                        && (state_reg == frwic_pkg::ST_RUN ||
                            state_reg == frwic_pkg::ST_SUS_WAIT ||
                            state_reg == frwic_pkg::ST_SUSP); // R7

   // ****************************************
   // Wishbone answer
   // ****************************************
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= WB_CYC_I && WB_STB_I && !ack_reg;
      end
   end

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rdata_reg <= 32'h0000_0000;
      end else if (rd_stb) begin
         case (WB_ADR_I)
            `FRWIC_OFS_CTRL: rdata_reg <= {28'h0000000, ctrl_reg};
            `FRWIC_OFS_PROT: rdata_reg <= {29'h00000000, prot_reg};
            `FRWIC_OFS_LOCK: rdata_reg <= {28'h0000000, lock_reg};
            `FRWIC_OFS_CMD:  rdata_reg <= {25'h0000000, op_reg};
            `FRWIC_OFS_STAT: rdata_reg <= {27'h0000000, IRQ_HOLD,
                             state_reg == frwic_pkg::ST_RECOV, abort_reg,
                             state_reg == frwic_pkg::ST_SUSP, !busy}; // R23
            default:         rdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   assign WB_ACK_O = ack_reg;
   assign WB_DAT_O = rdata_reg;

   // ****************************************
   // Control register and suspend request
   // ****************************************
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ctrl_reg <= `FRWIC_RST_CTRL;
         arm_reg  <= 3'h0;
      end else begin
         if (wr_stb && hit(`FRWIC_OFS_CTRL)) begin
            // Software sets or clears the suspend request; an auto-suspend set overrides a clear
            ctrl_reg[`FRWIC_CTRL_SUSREQ] <= WB_DAT_I[`FRWIC_CTRL_SUSREQ]; // R5
            // Enables: 0 arms, 1 right after an armed 0 takes
            arm_reg <= 3'h0;
            if (!WB_DAT_I[`FRWIC_CTRL_SUSIEN])
               ctrl_reg[`FRWIC_CTRL_SUSIEN] <= 1'b0;
            else if (arm_reg[0])
               ctrl_reg[`FRWIC_CTRL_SUSIEN] <= 1'b1; // R13
            if (!WB_DAT_I[`FRWIC_CTRL_LCREN])
               ctrl_reg[`FRWIC_CTRL_LCREN] <= 1'b0;
            else if (arm_reg[1])
               ctrl_reg[`FRWIC_CTRL_LCREN] <= 1'b1; // R13
            if (!WB_DAT_I[`FRWIC_CTRL_CPUREN])
               ctrl_reg[`FRWIC_CTRL_CPUREN] <= 1'b0;
            else if (arm_reg[2])
               ctrl_reg[`FRWIC_CTRL_CPUREN] <= 1'b1; // R13
            arm_reg <= ~WB_DAT_I[3:1];
         end else if (wr_stb) begin
            // Any other write breaks the pairing
            arm_reg <= 3'h0;
         end
         // Hardware set wins over a software clear
         if (auto_sus)
            ctrl_reg[`FRWIC_CTRL_SUSREQ] <= 1'b1; // R1
         if (state_reg == frwic_pkg::ST_IDLE && !cmd_go && !auto_sus
             && !(wr_stb && hit(`FRWIC_OFS_CTRL)))
            ctrl_reg[`FRWIC_CTRL_SUSREQ] <= 1'b0;
      end
   end

   // ****************************************
   // Protected enables and lock bits
   // ****************************************
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         prot_reg <= `FRWIC_RST_PROT;
      end else if (wr_stb && hit(`FRWIC_OFS_PROT)) begin
         // A 0 clears at once, a 1 only lands when armed
         prot_reg <= (prot_reg & WB_DAT_I[2:0]) | prot_set; // R13
      end
   end

   // Separate arm flops: 0 then 1 for enables, 1 then 0 for locks
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         parm_reg       <= 3'h0;
         unlock_arm_reg <= 4'h0;
         lock_reg       <= `FRWIC_RST_LOCK;
      end else if (wr_stb && hit(`FRWIC_OFS_LOCK)) begin
         parm_reg <= 3'h0;
         for (int i = 0; i < 4; i++) begin
            if (WB_DAT_I[i])
               lock_reg[i] <= 1'b1;
            else if (unlock_arm_reg[i])
               lock_reg[i] <= 1'b0; // R14
         end
         unlock_arm_reg <= WB_DAT_I[3:0];
      end else if (wr_stb && hit(`FRWIC_OFS_PROT)) begin
         unlock_arm_reg <= 4'h0;
         parm_reg       <= ~WB_DAT_I[2:0];
      end else if (wr_stb) begin
         parm_reg       <= 3'h0;
         unlock_arm_reg <= 4'h0;
      end
   end

   assign prot_set = (wr_stb && hit(`FRWIC_OFS_PROT))
                     ? (WB_DAT_I[2:0] & parm_reg) : 3'h0; // R13

   // ****************************************
   // Sequencer
   // ****************************************
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_reg <= frwic_pkg::ST_IDLE;
         op_reg    <= '0;
         cnt_reg   <= 16'h0000;
         done_reg  <= 16'h0000;
         abort_reg <= 1'b0;
      end else begin
         case (state_reg)
            frwic_pkg::ST_IDLE: begin
               if (cmd_go && !lock_reg[WB_DAT_I[4:3]]) begin
                  op_reg    <= WB_DAT_I[6:0];
                  done_reg  <= 16'h0000;
                  abort_reg <= 1'b0;
                  state_reg <= frwic_pkg::ST_RUN; // R23
               end
            end
            frwic_pkg::ST_RUN: begin
               // Interrupts run alongside; only suspend or abort stops it
               if (fatal_abort) begin
                  abort_reg <= 1'b1;
                  cnt_reg   <= RECOV_CYC[15:0];
                  state_reg <= frwic_pkg::ST_RECOV; // R7
               end else if (done_reg == op_len(op_reg.cmd)) begin
                  state_reg <= frwic_pkg::ST_IDLE; // R6
               end else if ((ctrl_reg[`FRWIC_CTRL_SUSREQ] || auto_sus)
                            && op_reg.cmd == `FRWIC_CMD_ERASE) begin
                  done_reg  <= done_reg + 16'h0001;
                  cnt_reg   <= 16'(`FRWIC_SUS_CYC);
                  state_reg <= frwic_pkg::ST_SUS_WAIT; // R10
               end else begin
                  done_reg <= done_reg + 16'h0001;
               end
            end
            frwic_pkg::ST_SUS_WAIT: begin
               // Erase progress count holds through the latency
               if (fatal_abort) begin
                  abort_reg <= 1'b1;
                  cnt_reg   <= RECOV_CYC[15:0];
                  state_reg <= frwic_pkg::ST_RECOV; // R7
               end else if (cnt_reg <= 16'h0001) begin
                  state_reg <= frwic_pkg::ST_SUSP; // R2
               end else begin
                  cnt_reg <= cnt_reg - 16'h0001;
               end
            end
            frwic_pkg::ST_SUSP: begin
               if (fatal_abort) begin
                  abort_reg <= 1'b1;
                  cnt_reg   <= RECOV_CYC[15:0];
                  state_reg <= frwic_pkg::ST_RECOV; // R7
               end else if (!ctrl_reg[`FRWIC_CTRL_SUSREQ]) begin
                  state_reg <= frwic_pkg::ST_RUN; // R5
               end
            end
            frwic_pkg::ST_RECOV: begin
               if (cnt_reg <= 16'h0001)
                  state_reg <= frwic_pkg::ST_IDLE; // R8
               else
                  cnt_reg <= cnt_reg - 16'h0001;
            end
            default: state_reg <= frwic_pkg::ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign FLASH_RESET      = (state_reg == frwic_pkg::ST_RECOV); // R7
   assign IRQ_HOLD         = (state_reg == frwic_pkg::ST_RECOV); // R8
   assign LOW_CURRENT_READ = ctrl_reg[`FRWIC_CTRL_LCREN];
   // Only the interrupted block is fenced while suspended
   assign ARRAY_GRANT = ARRAY_ACC.valid &&
                        (state_reg == frwic_pkg::ST_IDLE ||
                         (state_reg == frwic_pkg::ST_SUSP &&
                          ARRAY_ACC.block != op_reg.block)); // R4

endmodule

// *** shared/frwic_map.svh ***
// Register offsets, field positions, reset values and timing counts.
// Assumes a 20 MHz REF_CLK and a 32-bit classic Wishbone slave port.
`ifndef FRWIC_MAP_SVH
`define FRWIC_MAP_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define FRWIC_OFS_CTRL      6'h00
`define FRWIC_OFS_PROT      6'h04
`define FRWIC_OFS_LOCK      6'h08
`define FRWIC_OFS_CMD       6'h0C
`define FRWIC_OFS_STAT      6'h10
`define FRWIC_OFS_ADDR      6'h14

// ****************************************
// Control fields
// ****************************************
`define FRWIC_CTRL_SUSREQ   0
`define FRWIC_CTRL_SUSIEN   1
`define FRWIC_CTRL_LCREN    2
`define FRWIC_CTRL_CPUREN   3

// ****************************************
// Protected enable fields
// ****************************************
`define FRWIC_PROT_B        0
`define FRWIC_PROT_C        1
`define FRWIC_PROT_D        2

// ****************************************
// Status fields
// ****************************************
`define FRWIC_STAT_RDY      0
`define FRWIC_STAT_SUSP     1
`define FRWIC_STAT_ABORT    2
`define FRWIC_STAT_RECOV    3
`define FRWIC_STAT_HOLD     4

// ****************************************
// Commands
// ****************************************
`define FRWIC_CMD_ERASE     2'h1
`define FRWIC_CMD_PROG      2'h2

// ****************************************
// Reset values
// ****************************************
`define FRWIC_RST_CTRL      4'h0
`define FRWIC_RST_PROT      3'h0
`define FRWIC_RST_LOCK      4'hF

// ****************************************
// Timing (ns figures with derived cycle counts; erase and program given as cycles)
// ****************************************
`define FRWIC_CLK_NS        50
`define FRWIC_SUS_NS        1000
`define FRWIC_SUS_CYC       ((`FRWIC_SUS_NS) / (`FRWIC_CLK_NS))
`define FRWIC_RECOV_NS      5000
`define FRWIC_RECOV_CYC     ((`FRWIC_RECOV_NS) / (`FRWIC_CLK_NS))
`define FRWIC_ERASE_CYC     4000
`define FRWIC_PROG_CYC      400

`endif

// *** shared/frwic_pkg.sv ***
// Types of the flash rewrite and interrupt control block.
// Assumes frwic_map.svh for all numbers.
package frwic_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RUN,
      ST_SUS_WAIT,
      ST_SUSP,
      ST_RECOV
   } frwic_state_t;

   // Field order matches the command word: block, area, command
   typedef struct packed {
      logic [3:0]  block;
      logic        area_prog;
      logic [1:0]  cmd;
   } frwic_cmd_t;

   typedef struct packed {
      logic        valid;
      logic        we;
      logic [3:0]  block;
   } frwic_acc_t;

endpackage

// *** verification/frwic_top_assertions.sv ***
// Port-level checks for the flash rewrite control block.
// Assumes a bind onto frwic_top with its timing parameters.
`timescale 1ns/10ps
`include "frwic_map.svh"
module frwic_top_assertions #(
   parameter int ERASE_CYC = 40,
   parameter int PROG_CYC  = 10,
   parameter int RECOV_CYC = 5
) (
   // Clock and reset
   input wire logic                  REF_CLK,
   input wire logic                  ARST_N,
   // Wishbone
   input wire logic                  WB_CYC_I,
   input wire logic                  WB_STB_I,
   input wire logic                  WB_WE_I,
   input wire logic [5:0]            WB_ADR_I,
   input wire logic [3:0]            WB_SEL_I,
   input wire logic [31:0]           WB_DAT_I,
   input wire logic [31:0]           WB_DAT_O,
   input wire logic                  WB_ACK_O,
   // Interrupts
   input wire logic                  IRQ_ACK,
   input wire logic                  IRQ_ACK_FATAL,
   input wire logic                  IRQ_HOLD,
   // Array and flash state
   input wire frwic_pkg::frwic_acc_t ARRAY_ACC,
   input wire logic                  ARRAY_GRANT,
   input wire logic                  FLASH_RESET,
   input wire logic                  LOW_CURRENT_READ
);
   // ****************************************
   // Helpers
   // ****************************************
   logic        req;
   logic        ctrl_wr;
   logic        lcr_one;
   logic [15:0] rcnt;
   assign req     = WB_CYC_I & WB_STB_I;
   assign ctrl_wr = req & WB_WE_I & (WB_ADR_I == `FRWIC_OFS_CTRL);
   assign lcr_one = ctrl_wr & WB_DAT_I[`FRWIC_CTRL_LCREN];
   // Length of the current recovery window
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rcnt <= 16'h0000;
      end else if (FLASH_RESET) begin
         rcnt <= rcnt + 16'h0001;
      end else begin
         rcnt <= 16'h0000;
      end
   end
   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!ARST_N);
   sequence s_take;
      WB_CYC_I && WB_STB_I && !WB_ACK_O;
   endsequence
   sequence s_recov_done;
      $fell(FLASH_RESET);
   endsequence
   property p_ack_next;
      s_take |=> WB_ACK_O;
   endproperty
   property p_ack_pulse;
      WB_ACK_O |=> !WB_ACK_O;
   endproperty
   property p_ack_cause;
      WB_ACK_O |-> $past(req);
   endproperty
   property p_hold_with_reset;
      FLASH_RESET |-> IRQ_HOLD;
   endproperty
   property p_abort_cause;
      $rose(FLASH_RESET) |-> $past(IRQ_ACK_FATAL) || $past(IRQ_ACK_FATAL, 2);
   endproperty
   property p_recov_len;
      s_recov_done |-> rcnt >= RECOV_CYC && rcnt <= RECOV_CYC + 1;
   endproperty
   property p_hold_release;
      s_recov_done |-> ##[0:2] !IRQ_HOLD;
   endproperty
   property p_lcr_cause;
      !$stable(LOW_CURRENT_READ) |-> $past(ctrl_wr) || $past(ctrl_wr, 2);
   endproperty
   property p_grant_valid;
      ARRAY_GRANT |-> ARRAY_ACC.valid && !FLASH_RESET;
   endproperty
   property p_lcr_rise;
      $rose(LOW_CURRENT_READ) |-> $past(lcr_one) || $past(lcr_one, 2);
   endproperty
   a_ack_next: assert property (p_ack_next)
      else $error("no ack one cycle after request");
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (p_ack_cause)
      else $error("ack without request");
   a_hold_with_reset: assert property (p_hold_with_reset)
      else $error("flash reset without interrupt hold");
   a_abort_cause: assert property (p_abort_cause)
      else $error("flash reset without fatal interrupt");
   a_recov_len: assert property (p_recov_len)
      else $error("recovery window has wrong length");
   a_hold_release: assert property (p_hold_release)
      else $error("interrupt hold stays after recovery");
   a_lcr_cause: assert property (p_lcr_cause)
      else $error("low-current read changed without control write");
   a_lcr_rise: assert property (p_lcr_rise)
      else $error("low-current read set without a written one");
   a_grant_valid: assert property (p_grant_valid)
      else $error("array grant without request or during recovery");
endmodule

// *** verification/tb_frwic_top.sv ***
// Self-checking bench for the flash rewrite control block.
// Assumes frwic_pkg compiled first and frwic_map.svh on the include path.
`timescale 1ns/10ps
`include "frwic_map.svh"
module tb_frwic_top;
   // ****************************************
   // Signals and helpers
   // ****************************************
   logic                  clk;
   logic                  rst_n;
   logic                  cyc;
   logic                  stb;
   logic                  we;
   logic                  irq;
   logic                  fatal;
   logic [5:0]            adr;
   logic [3:0]            sel;
   logic [31:0]           wdat;
   logic [31:0]           rdat;
   logic [31:0]           q;
   logic                  ack;
   logic                  hold;
   logic                  grant;
   logic                  frst;
   logic                  lcr;
   frwic_pkg::frwic_acc_t acc;
   int                    fails;
   int                    checks;
   int                    n;
   int                    k;
   // Short counts keep the run brief
   frwic_top #(.ERASE_CYC(40), .PROG_CYC(10), .RECOV_CYC(5)) uut (
      .REF_CLK(clk), .ARST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
      .WB_DAT_O(rdat), .WB_ACK_O(ack), .IRQ_ACK(irq),
      .IRQ_ACK_FATAL(fatal), .IRQ_HOLD(hold), .ARRAY_ACC(acc),
      .ARRAY_GRANT(grant), .FLASH_RESET(frst), .LOW_CURRENT_READ(lcr));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic timeout_hit();
      fails++;
      $display("MISMATCH %0t wait ran out", $time);
      tally_and_finish();
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Classic cycle: hold until ack is sampled high
   task automatic wb(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
      int m;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      m = 0;
      do begin
         @(posedge clk);
         m++;
      end while (ack !== 1'b1 && m < 20);
      q = rdat;
      if (m >= 20) timeout_hit();
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] m,
                     input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(q & m, e);
   endtask
   task automatic wait_stat(input int b, input logic v);
      n = 0;
      do begin
         wb(1'b0, `FRWIC_OFS_STAT, 32'h0);
         n++;
      end while (q[b] !== v && n < 60);
      if (n >= 60) timeout_hit();
   endtask
   task automatic pulse(input logic f);
      if (f) fatal <= 1'b1;
      else irq <= 1'b1;
      @(posedge clk);
      fatal <= 1'b0;
      irq   <= 1'b0;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset_values();
      wr(6'h3C, 32'hFFFF_FFFF);
      rd(6'h3C, 32'hFFFF_FFFF, 32'h0);
      rd(`FRWIC_OFS_CTRL, 32'hF, 32'h0);
      rd(`FRWIC_OFS_PROT, 32'h7, 32'h0);
      rd(`FRWIC_OFS_LOCK, 32'hF, 32'hF);
      rd(`FRWIC_OFS_STAT, 32'h1F, 32'h1);
   endtask
   task automatic t_protect();
      wr(`FRWIC_OFS_CTRL, 32'h4);
      chk(lcr, 1'b0);
      wr(`FRWIC_OFS_CTRL, 32'h0);
      wr(`FRWIC_OFS_PROT, 32'h0);
      wr(`FRWIC_OFS_CTRL, 32'h4);
      chk(lcr, 1'b0);
      wr(`FRWIC_OFS_CTRL, 32'h0);
      wr(`FRWIC_OFS_CTRL, 32'h4);
      chk(lcr, 1'b1);
      wr(`FRWIC_OFS_PROT, 32'h0);
      wr(`FRWIC_OFS_PROT, 32'h7);
      rd(`FRWIC_OFS_PROT, 32'h7, 32'h7);
      wr(`FRWIC_OFS_LOCK, 32'h0);
      rd(`FRWIC_OFS_LOCK, 32'hF, 32'hF);
      wr(`FRWIC_OFS_LOCK, 32'hF);
      wr(`FRWIC_OFS_LOCK, 32'h0);
      rd(`FRWIC_OFS_LOCK, 32'hF, 32'h0);
      wr(`FRWIC_OFS_CTRL, 32'h0);
      wr(`FRWIC_OFS_CTRL, 32'hA);
      rd(`FRWIC_OFS_CTRL, 32'hF, 32'hA);
   endtask
   task automatic t_suspend();
      wr(`FRWIC_OFS_CMD, 32'h09);
      rd(`FRWIC_OFS_STAT, 32'h1, 32'h0);
      pulse(1'b0);
      rd(`FRWIC_OFS_CTRL, 32'h1, 32'h1);
      wait_stat(`FRWIC_STAT_SUSP, 1'b1);
      chk(32'(n >= 5 && n <= 8), 32'h1);
      acc <= '{valid: 1'b1, we: 1'b0, block: 4'h1};
      @(posedge clk);
      @(posedge clk);
      chk(grant, 1'b0);
      acc <= '{valid: 1'b1, we: 1'b1, block: 4'h2};
      @(posedge clk);
      @(posedge clk);
      chk(grant, 1'b1);
      acc <= '0;
      wr(`FRWIC_OFS_CTRL, 32'hA);
      wait_stat(`FRWIC_STAT_SUSP, 1'b0);
      chk(32'(n <= 2), 32'h1);
      wait_stat(`FRWIC_STAT_RDY, 1'b1);
   endtask
   task automatic t_concurrent();
      wr(`FRWIC_OFS_CTRL, 32'h0);
      wr(`FRWIC_OFS_CTRL, 32'h8);
      wr(`FRWIC_OFS_CMD, 32'h11);
      pulse(1'b0);
      rd(`FRWIC_OFS_CTRL, 32'h1, 32'h0);
      chk(hold, 1'b0);
      wr(`FRWIC_OFS_CTRL, 32'h9);
      wait_stat(`FRWIC_STAT_SUSP, 1'b1);
      wr(`FRWIC_OFS_CTRL, 32'h8);
      wait_stat(`FRWIC_STAT_RDY, 1'b1);
      wr(`FRWIC_OFS_CMD, 32'h12);
      pulse(1'b0);
      rd(`FRWIC_OFS_STAT, 32'h3, 32'h0);
      wait_stat(`FRWIC_STAT_RDY, 1'b1);
   endtask
   task automatic t_abort();
      wr(`FRWIC_OFS_CMD, 32'h1E);
      pulse(1'b1);
      n = 0;
      k = 0;
      repeat (12) begin
         @(posedge clk);
         if (frst === 1'b1) n++;
         if (frst === 1'b1 && hold !== 1'b1) k++;
      end
      chk(32'(n >= 5 && n <= 6), 32'h1);
      chk(32'(k), 32'h0);
      rd(`FRWIC_OFS_STAT, 32'h5, 32'h5);
      wr(`FRWIC_OFS_CMD, 32'h1D);
      rd(`FRWIC_OFS_STAT, 32'h5, 32'h0);
      wait_stat(`FRWIC_STAT_RDY, 1'b1);
      wr(`FRWIC_OFS_LOCK, 32'h1);
      wr(`FRWIC_OFS_CMD, 32'h01);
      rd(`FRWIC_OFS_STAT, 32'h1, 32'h1);
   endtask
   initial begin
      {rst_n, cyc, stb, we, irq, fatal} = 6'h00;
      adr    = 6'h00;
      sel    = 4'hF;
      wdat   = 32'h0;
      acc    = '0;
      fails  = 0;
      checks = 0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_reset_values();
      t_protect();
      t_suspend();
      t_concurrent();
      t_abort();
      tally_and_finish();
   end
endmodule
bind frwic_top frwic_top_assertions #(.ERASE_CYC(ERASE_CYC),
   .PROG_CYC(PROG_CYC), .RECOV_CYC(RECOV_CYC)) u_chk (
   .REF_CLK(REF_CLK), .ARST_N(ARST_N), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
   .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
   .WB_ACK_O(WB_ACK_O), .IRQ_ACK(IRQ_ACK), .IRQ_ACK_FATAL(IRQ_ACK_FATAL),
   .IRQ_HOLD(IRQ_HOLD), .ARRAY_ACC(ARRAY_ACC), .ARRAY_GRANT(ARRAY_GRANT),
   .FLASH_RESET(FLASH_RESET), .LOW_CURRENT_READ(LOW_CURRENT_READ));
